// ---- bench/sisp_programmer.sv ----
`timescale 1ns/1ps
module sisp_programmer #(
  parameter int HALF = 8
)(
  input wire logic sys_clk_in,
  input wire logic sdo_in,
  output logic sck_out,
  output logic sdi_out
);
  // Link clock rests low between frames
  initial
  begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end
  ////////////////////////////////////////
  // Whole four-byte frame, MSB first; a short frame would desync the device for good
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    int i;
    rx = '0;
    for (i = 31; i >= 0; i--)
    begin
      @(posedge sys_clk_in);
      sdi_out <= tx[i];
      repeat (HALF) @(posedge sys_clk_in);
      sck_out <= 1'b1;
      rx[i] = sdo_in;
      repeat (HALF) @(posedge sys_clk_in);
      sck_out <= 1'b0;
    end
    // Idle data line flips so a stale level is never mistaken for data
    @(posedge sys_clk_in);
    sdi_out <= ~tx[0];
    repeat (HALF) @(posedge sys_clk_in);
  endtask : xfer
endmodule : sisp_programmer

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top;
  import sisp_pkg::*;
  localparam logic [7:0] CAL = 8'h5a;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sck, sdi, sdo, busy, prog_en;
  int n_fail = 0;
  int checks_done = 0;
  logic [31:0] rx;
  logic [7:0] wsub [4] = '{SUB_LOCK, SUB_FUSE_LO, SUB_FUSE_HI, SUB_FUSE_EXT};
  logic [7:0] rop [4] = '{OP_READ_LOCK, OP_READ_FUSE, OP_READ_LOCK, OP_READ_FUSE};
  logic [7:0] rb2 [4] = '{8'h00, 8'h00, SUB_HIGH_SEL, SUB_HIGH_SEL};
  logic [7:0] fval [4] = '{8'hfc, 8'hde, 8'hd9, 8'hfd};

  always #5 sys_clk_in = ~sys_clk_in;

  // Short self-timed waits keep the run small
  sisp_decoder #(.FLASH_AW(10), .WRITE_CYCLES(20), .ERASE_CYCLES(20),
    .SIGNATURE(24'h0a0b0c), .CAL_BYTE(CAL)) uut ( // Signature value is arbitrary
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .sdi_in(sdi),
    .sdo_out(sdo), .busy_out(busy), .prog_en_out(prog_en));
  sisp_programmer prog (.sys_clk_in(sys_clk_in), .sdo_in(sdo), .sck_out(sck), .sdi_out(sdi));

  ////////////////////////////////////////
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic send(input logic [7:0] op, b2, b3, b4);
    sisp_instr_t ins;
    ins = '{op, b2, b3, b4};
    prog.xfer(ins, rx);
  endtask : send

  task automatic wait_ready();
    int k;
    k = 0;
    send(OP_POLL, 8'h00, 8'h00, 8'h00);
    while (rx[0] !== 1'b0)
    begin
      k++;
      if (k > 100)
      begin
        n_fail++;
        conclude();
      end
      send(OP_POLL, 8'h00, 8'h00, 8'h00);
    end
  endtask : wait_ready

  task automatic rd(input logic [7:0] op, b2, b3, exp);
    send(op, b2, b3, 8'h00);
    `CHK(rx[7:0], exp)
  endtask : rd

  ////////////////////////////////////////
  task automatic t_enable();
    send(OP_POLL, 8'h00, 8'h00, 8'h00);
    `CHK(prog_en, 1'b0)
    send(OP_ENABLE, SUB_ENABLE, 8'h00, 8'h00);
    `CHK(rx[15:8], SUB_ENABLE)
    `CHK(prog_en, 1'b1)
  endtask : t_enable

  task automatic t_erase();
    send(OP_ENABLE, SUB_ERASE, 8'h00, 8'h00);
    `CHK(busy, 1'b1)
    send(OP_POLL, 8'h00, 8'h00, 8'h00);
    `CHK(rx[0], 1'b1)
    wait_ready();
    rd(OP_READ_LO, 8'h00, 8'h05, ERASED_BYTE);
    rd(OP_READ_HI, 8'h03, 8'hff, ERASED_BYTE);
    rd(OP_READ_EE, 8'h00, 8'h07, ERASED_BYTE);
  endtask : t_erase

  task automatic t_flash();
    send(OP_EXT_ADDR, 8'h00, 8'h00, 8'h00);
    send(OP_LOAD_LO, 8'h00, 8'h03, 8'h13);
    send(OP_LOAD_HI, 8'h00, 8'h03, 8'hc3);
    send(OP_LOAD_LO, 8'h00, 8'h01, 8'h11);
    send(OP_LOAD_HI, 8'h00, 8'h01, 8'hc1);
    send(OP_WRITE_PAGE, 8'h01, 8'h00, 8'h00);
    `CHK(busy, 1'b1)
    wait_ready();
    `CHK(busy, 1'b0)
    rd(OP_READ_LO, 8'h01, 8'h03, 8'h13);
    rd(OP_READ_HI, 8'h01, 8'h03, 8'hc3);
    rd(OP_READ_HI, 8'h01, 8'h01, 8'hc1);
  endtask : t_flash

  task automatic t_eeprom();
    send(OP_WRITE_EE, 8'h00, 8'h41, 8'h66);
    wait_ready();
    rd(OP_READ_EE, 8'h00, 8'h41, 8'h66);
    send(OP_LOAD_EE, 8'h00, 8'h00, 8'h9c);
    send(OP_LOAD_EE, 8'h00, 8'h02, 8'h3e);
    send(OP_WRITE_EE_PG, 8'h00, 8'h40, 8'h00);
    wait_ready();
    rd(OP_READ_EE, 8'h00, 8'h40, 8'h9c);
    rd(OP_READ_EE, 8'h00, 8'h42, 8'h3e);
    rd(OP_READ_EE, 8'h00, 8'h41, 8'h66);
  endtask : t_eeprom

  task automatic t_fuses();
    int i;
    for (i = 0; i < 4; i++)
    begin
      send(OP_ENABLE, wsub[i], 8'h00, fval[i]);
      wait_ready();
      rd(rop[i], rb2[i], 8'h00, fval[i]);
    end
    rd(OP_READ_CAL, 8'h00, 8'h00, CAL);
    rd(OP_READ_SIG, 8'h00, 8'h00, 8'h0a);
  endtask : t_fuses

  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    t_fuses();
    conclude();
  end

  // Roughly forty-three frames of about 550 cycles each are expected
  initial
  begin
    repeat (90000) @(posedge sys_clk_in);
    n_fail++;
    conclude();
  end
endmodule : tb_top

// ---- hdl/sisp_decoder.sv ----
`timescale 1ns/1ps
// Function
// - Enable instruction first; echo second byte during third
// - Sample on rising, shift out on falling
// - AC 80 erases program and EEPROM memory
// - Erase leaves every location reading all ones
// - Poll returns bit0 set while busy
// - 4D latches third byte as extended address
// - 48 loads page buffer word high byte
// - 40 loads page buffer word low byte
// - C1 loads EEPROM page buffer byte
// - 28/20 read program word high/low byte
// - Return lock, fuse, calibration, signature bytes
// - 4C commits program page, busy until done
// - C2 commits EEPROM page buffer
// - EEPROM page write alters only loaded bytes
// - AC E0/A0/A8/A4 write lock and fuses
// - Zero bit programmed, one bit unprogrammed
// - Word addresses, any order within page
module sisp_decoder
  import sisp_pkg::*;
#(
  parameter int FLASH_AW = 14,
  parameter int PAGE_AW = 6,
  parameter int EE_AW = 10,
  parameter int EE_PAGE_AW = 2,
  parameter int WRITE_CYCLES = WRITE_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter logic [23:0] SIGNATURE = 24'h123456, // Arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
)(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic busy_out,
  output logic prog_en_out
);
  ////////////////////////////////////////////////////////////////
  logic rst_a_r, rst_b_r;
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end
    else
    begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  wire rst_n = rst_b_r;

  // Two-stage sync; only the second stage feeds logic
  logic [1:0] sck_s1_r, sck_s2_r;
  logic sck_old_r, sdi_s2_r;
  always_ff @(posedge sys_clk_in or negedge rst_n)
    if (!rst_n)
    begin
      sck_s1_r <= 2'h0;
      sck_s2_r <= 2'h0;
      sck_old_r <= 1'b0;
    end
    else
    begin
      sck_s1_r <= {sdi_in, sck_in};
      sck_s2_r <= sck_s1_r;
      sck_old_r <= sck_s2_r[0];
    end
  assign sdi_s2_r = sck_s2_r[1];
  wire sck_rise = sck_s2_r[0] & ~sck_old_r;
  wire sck_fall = ~sck_s2_r[0] & sck_old_r;

  ////////////////////////////////////////////////////////////////
  // Shift in on rising edge, shift out on falling edge
  logic [31:0] shin_r;
  logic [4:0] bitcnt_r;
  logic [7:0] shout_r;
  logic [7:0] tx_byte;
  logic [7:0] rd_byte;
  logic done_r;
  sisp_instr_t ins;
  assign ins = shin_r;
  always_ff @(posedge sys_clk_in or negedge rst_n)
    if (!rst_n)
    begin
      shin_r <= 32'h0;
      bitcnt_r <= 5'h0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (sck_rise)
      begin
        shin_r <= {shin_r[30:0], sdi_s2_r};
        bitcnt_r <= bitcnt_r + 5'h1;
        done_r <= (bitcnt_r == 5'h1f);
      end
    end

  // Reply byte chosen at each byte boundary, first bit shown at the next falling edge
  always_ff @(posedge sys_clk_in or negedge rst_n)
    if (!rst_n)
    begin
      shout_r <= 8'h0;
      sdo_out <= 1'b0;
    end
    else if (sck_fall)
    begin
      if (bitcnt_r[2:0] == 3'h0)
      begin
        sdo_out <= tx_byte[7];
        shout_r <= {tx_byte[6:0], 1'b0};
      end
      else
      begin
        sdo_out <= shout_r[7];
        shout_r <= {shout_r[6:0], 1'b0};
      end
    end

  ////////////////////////////////////////////////////////////////
  // Memories and nonvolatile bytes
  logic [15:0] flash_m [2**FLASH_AW];
  logic [7:0] ee_m [2**EE_AW];
  logic [15:0] pg_buf [2**PAGE_AW];
  logic [7:0] ee_buf [2**EE_PAGE_AW];
  logic [2**EE_PAGE_AW-1:0] ee_ld_r;
  logic [7:0] lock_r, fuse_lo_r, fuse_hi_r, fuse_ext_r, ext_addr_r;
  logic [FLASH_AW-1:0] pg_addr_r;
  logic [EE_AW-1:0] ee_addr_r;
  logic [31:0] cnt_r;
  logic [FLASH_AW:0] idx_r;
  sisp_state_t st_r;

  wire [15:0] adr16 = {ins.b2, ins.b3};
  wire [FLASH_AW-1:0] f_adr = adr16[FLASH_AW-1:0];
  wire [EE_AW-1:0] e_adr = adr16[EE_AW-1:0];
  wire [PAGE_AW-1:0] w_idx = ins.b3[PAGE_AW-1:0];
  wire [EE_PAGE_AW-1:0] e_idx = ins.b3[EE_PAGE_AW-1:0];

  // Byte 2 echoes during byte 3; the read reply fills byte 4
  always_comb
  begin
    tx_byte = 8'h0;
    if (bitcnt_r == 5'h10)
      tx_byte = shin_r[7:0];
    else if (bitcnt_r == 5'h18)
      tx_byte = rd_byte;
  end

  ////////////////////////////////////////////////////////////////
  // Instruction decode and self-timed operations
  always_ff @(posedge sys_clk_in or negedge rst_n)
    if (!rst_n)
    begin
      st_r <= SISP_IDLE;
      prog_en_out <= 1'b0;
      busy_out <= 1'b0;
      cnt_r <= 32'h0;
      idx_r <= '0;
      ext_addr_r <= 8'h0;
      pg_addr_r <= '0;
      ee_addr_r <= '0;
      ee_ld_r <= '0;
      lock_r <= ERASED_BYTE;
      fuse_lo_r <= ERASED_BYTE;
      fuse_hi_r <= ERASED_BYTE;
      fuse_ext_r <= ERASED_BYTE;
    end
    else
    begin
      busy_out <= (st_r != SISP_IDLE);
      case (st_r)
        SISP_IDLE:
          if (done_r && ins.op == OP_ENABLE && ins.b2 == SUB_ENABLE)
            prog_en_out <= 1'b1;
          else if (done_r && prog_en_out)
          begin
            case (ins.op)
              OP_ENABLE:
                case (ins.b2)
                  SUB_ERASE:
                  begin
                    st_r <= SISP_ERASE;
                    idx_r <= '0;
                    cnt_r <= 32'(ERASE_CYCLES);
                    lock_r <= ERASED_BYTE;
                  end
                  SUB_LOCK: lock_r <= ins.b4;
                  SUB_FUSE_LO: fuse_lo_r <= ins.b4;
                  SUB_FUSE_HI: fuse_hi_r <= ins.b4;
                  SUB_FUSE_EXT: fuse_ext_r <= ins.b4;
                  default: ;
                endcase
              OP_EXT_ADDR: ext_addr_r <= ins.b3;
              OP_LOAD_HI: pg_buf[w_idx][15:8] <= ins.b4;
              OP_LOAD_LO: pg_buf[w_idx][7:0] <= ins.b4;
              OP_LOAD_EE:
              begin
                ee_buf[e_idx] <= ins.b4;
                ee_ld_r[e_idx] <= 1'b1;
              end
              OP_WRITE_PAGE:
              begin
                st_r <= SISP_COMMIT_PG;
                pg_addr_r <= f_adr;
                idx_r <= '0;
                cnt_r <= 32'(WRITE_CYCLES);
              end
              OP_WRITE_EE:
              begin
                ee_m[e_adr] <= ins.b4;
                st_r <= SISP_WAIT;
                cnt_r <= 32'(WRITE_CYCLES);
              end
              OP_WRITE_EE_PG:
              begin
                st_r <= SISP_COMMIT_EE;
                ee_addr_r <= e_adr;
                idx_r <= '0;
                cnt_r <= 32'(WRITE_CYCLES);
              end
              default: ;
            endcase
          end
        SISP_ERASE:
        begin
          if (idx_r < (FLASH_AW + 1)'(2**FLASH_AW))
          begin
            flash_m[idx_r[FLASH_AW-1:0]] <= {ERASED_BYTE, ERASED_BYTE};
            if (idx_r < (FLASH_AW + 1)'(2**EE_AW))
              ee_m[idx_r[EE_AW-1:0]] <= ERASED_BYTE;
            idx_r <= idx_r + 1'b1;
          end
          st_r <= SISP_WAIT;
          if (idx_r < (FLASH_AW + 1)'(2**FLASH_AW - 1))
            st_r <= SISP_ERASE;
        end
        SISP_COMMIT_PG:
        begin
          flash_m[{pg_addr_r[FLASH_AW-1:PAGE_AW], idx_r[PAGE_AW-1:0]}] <=
            pg_buf[idx_r[PAGE_AW-1:0]];
          idx_r <= idx_r + 1'b1;
          if (idx_r == (FLASH_AW + 1)'(2**PAGE_AW - 1))
            st_r <= SISP_WAIT;
        end
        SISP_COMMIT_EE:
        begin
          if (ee_ld_r[idx_r[EE_PAGE_AW-1:0]])
            ee_m[{ee_addr_r[EE_AW-1:EE_PAGE_AW], idx_r[EE_PAGE_AW-1:0]}] <=
              ee_buf[idx_r[EE_PAGE_AW-1:0]];
          idx_r <= idx_r + 1'b1;
          if (idx_r == (FLASH_AW + 1)'(2**EE_PAGE_AW - 1))
          begin
            st_r <= SISP_WAIT;
            ee_ld_r <= '0;
          end
        end
        SISP_WAIT:
        begin
          if (cnt_r <= 32'h1)
            st_r <= SISP_IDLE;
          else
            cnt_r <= cnt_r - 32'h1;
        end
        default: st_r <= SISP_IDLE;
      endcase
    end

  ////////////////////////////////////////////////////////////////
  // Fourth-slot reply, computed once the first three bytes are in
  wire [23:0] h3 = shin_r[23:0];
  wire [15:0] ra = h3[15:0];
  always_comb
  begin
    rd_byte = 8'h0;
    case (h3[23:16])
      OP_POLL: rd_byte = {7'h0, st_r != SISP_IDLE};
      OP_READ_HI: rd_byte = flash_m[ra[FLASH_AW-1:0]][15:8];
      OP_READ_LO: rd_byte = flash_m[ra[FLASH_AW-1:0]][7:0];
      OP_READ_EE: rd_byte = ee_m[ra[EE_AW-1:0]];
      OP_READ_LOCK: rd_byte = (ra[15:8] == SUB_HIGH_SEL) ? fuse_hi_r : lock_r;
      OP_READ_FUSE: rd_byte = (ra[15:8] == SUB_HIGH_SEL) ? fuse_ext_r : fuse_lo_r;
      OP_READ_CAL: rd_byte = CAL_BYTE;
      OP_READ_SIG: rd_byte = SIGNATURE[8*(2 - int'(ra[1:0] > 2'h2 ? 2'h2 : ra[1:0])) +: 8];
      default: rd_byte = 8'h0;
    endcase
  end
  ////////////////////////////////////////////////////////////////
  property p_busy_follows;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (st_r != SISP_IDLE) |=> busy_out;
  endproperty
  a_busy_follows: assert property (p_busy_follows) else $error("busy not shown");
  property p_enable;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (done_r && ins.op == OP_ENABLE && ins.b2 == SUB_ENABLE) |=> prog_en_out;
  endproperty
  a_enable: assert property (p_enable) else $error("enable not taken");
  property p_locked_idle;
    @(posedge sys_clk_in) disable iff (!rst_n) (done_r && !prog_en_out) |=> (st_r == SISP_IDLE);
  endproperty
  a_locked_idle: assert property (p_locked_idle) else $error("acted before enable");
  property p_echo;
    @(posedge sys_clk_in) disable iff (!rst_n) (sck_fall && bitcnt_r == 5'h10) |=> (sdo_out == $past(shin_r[7]));
  endproperty
  a_echo: assert property (p_echo) else $error("echo bit wrong");
  property p_poll_top;
    @(posedge sys_clk_in) disable iff (!rst_n) (sck_fall && bitcnt_r == 5'h18 && shin_r[23:16] == OP_POLL) |=> !sdo_out;
  endproperty
  a_poll_top: assert property (p_poll_top) else $error("poll upper bit set");
  property p_lock_write;
    @(posedge sys_clk_in) disable iff (!rst_n) (st_r == SISP_IDLE && done_r && prog_en_out && ins.op == OP_ENABLE && ins.b2 == SUB_LOCK) |=> (lock_r == $past(ins.b4));
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("lock byte not written");
endmodule : sisp_decoder

// ---- hdl/sisp_pkg.sv ----
package sisp_pkg;
  // Instruction first bytes
  localparam logic [7:0] OP_ENABLE = 8'hac;
  localparam logic [7:0] OP_POLL = 8'hf0;
  localparam logic [7:0] OP_EXT_ADDR = 8'h4d;
  localparam logic [7:0] OP_LOAD_HI = 8'h48;
  localparam logic [7:0] OP_LOAD_LO = 8'h40;
  localparam logic [7:0] OP_LOAD_EE = 8'hc1;
  localparam logic [7:0] OP_READ_HI = 8'h28;
  localparam logic [7:0] OP_READ_LO = 8'h20;
  localparam logic [7:0] OP_READ_EE = 8'ha0;
  localparam logic [7:0] OP_READ_LOCK = 8'h58;
  localparam logic [7:0] OP_READ_SIG = 8'h30;
  localparam logic [7:0] OP_READ_FUSE = 8'h50;
  localparam logic [7:0] OP_READ_CAL = 8'h38;
  localparam logic [7:0] OP_WRITE_PAGE = 8'h4c;
  localparam logic [7:0] OP_WRITE_EE = 8'hc0;
  localparam logic [7:0] OP_WRITE_EE_PG = 8'hc2;
  // Second bytes under the enable group, plus the high-byte select for lock and fuse reads
  localparam logic [7:0] SUB_ENABLE = 8'h53;
  localparam logic [7:0] SUB_ERASE = 8'h80;
  localparam logic [7:0] SUB_LOCK = 8'he0;
  localparam logic [7:0] SUB_FUSE_LO = 8'ha0;
  localparam logic [7:0] SUB_FUSE_HI = 8'ha8;
  localparam logic [7:0] SUB_FUSE_EXT = 8'ha4;
  localparam logic [7:0] SUB_HIGH_SEL = 8'h08;
  // Erased and unprogrammed value: one means unprogrammed
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Self-timed durations
  localparam int CLK_MHZ = 100;
  localparam int T_WRITE_US = 4500;
  localparam int T_ERASE_US = 9000;
  localparam int WRITE_CYC = T_WRITE_US * CLK_MHZ;
  localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } sisp_instr_t;

  typedef enum {
    SISP_IDLE,
    SISP_ERASE,
    SISP_COMMIT_PG,
    SISP_COMMIT_EE,
    SISP_WAIT
  } sisp_state_t;
endpackage : sisp_pkg
